// ### src/rsc_map.svh
// Register offsets, field positions, reset values and timing counts of the reset source controller.
// Assumes inclusion by bare name from the package and the bench.
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

// Register indices; byte address is four times the index
`define RSC_IDX_CAUSE_FLAGS  2'h0
`define RSC_IDX_SW_RESET     2'h1
`define RSC_IDX_PROT_KEY     2'h2
`define RSC_IDX_BOD_CONFIG   2'h3

// Cause flag bit positions, then the software reset trigger bit
`define RSC_BIT_POWERON      0
`define RSC_BIT_BROWNOUT     1
`define RSC_BIT_PIN          2
`define RSC_BIT_WATCHDOG     3
`define RSC_BIT_SOFTWARE     4
`define RSC_BIT_DEBUG        5
`define RSC_BIT_SW_TRIGGER   0

// Reset values
`define RSC_RST_CAUSE_FLAGS  6'h01
`define RSC_RST_BOD_CONFIG   3'h0
`define RSC_BOD_MIN_LEVEL    3'h0

// Key opening the protected write window (value is arbitrary)
`define RSC_IO_REGISTER_KEY  8'h9D

// Protected write window: four instructions, two bus cycles each
`define RSC_KEY_WINDOW_INSTR 4
`define RSC_CYCLES_PER_INSTR 2

// Internal initialization lengths in cycles
`define RSC_INIT_BASE        16
`define RSC_INIT_SUT_UNIT    64
`define RSC_INIT_CRC_EXTRA   256

`endif

// ### src/rsc_pkg.sv
// Types shared by the reset source controller.
// Assumes rsc_map.svh is on the include path.
package rsc_pkg;
  `include "rsc_map.svh"

  typedef enum logic [1:0] {
    RSC_HOLD,
    RSC_INIT,
    RSC_RUN
  } rsc_state_e;

  typedef logic [5:0] rsc_flags_t;
  typedef logic [2:0] rsc_bod_t;
endpackage

// ### src/rsc_reset_source_controller.sv
// Reset source controller: gathers six reset sources, sequences the system reset, records causes.
// Assumes one 125 MHz clock, an Avalon-MM master and reset_n as the power-on detector output.
`timescale 1ns/1ns

module rsc_reset_source_controller
  import rsc_pkg::*;
#(
  parameter int INIT_BASE     = `RSC_INIT_BASE,
  parameter int INIT_SUT_UNIT = `RSC_INIT_SUT_UNIT,
  parameter int INIT_CRC      = `RSC_INIT_CRC_EXTRA
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        brownOutDetect,
  input  wire logic        resetPin_n,
  input  wire logic        watchdogTimeout,
  input  wire logic        debugResetRequest,
  input  wire logic        chipErase,
  input  wire logic        pinResetFuse,
  input  wire logic        bodUnusedFuse,
  input  wire logic [1:0]  startupDelayFuse,
  input  wire logic        bootCrcSourceFuse,
  output logic             systemReset_n,
  output logic             debugReset_n,
  output logic             fuseReload,
  output logic             pinResetEnable,
  output logic             bodUnused,
  output logic [1:0]       startupDelay,
  output logic             bootCrcSource,
  output rsc_pkg::rsc_bod_t bodLevel
);
  import rsc_pkg::*;

  localparam int KEY_CYCLES = `RSC_KEY_WINDOW_INSTR * `RSC_CYCLES_PER_INSTR;
  localparam int CNT_W      = 12;

  rsc_state_e   state;
  rsc_flags_t   causeFlags;
  rsc_flags_t   srcActive;
  logic         bootDone;
  logic [2:0]   pinSync;
  logic         pinLevel_n;
  logic         bodSync1;
  logic         bodSync2;
  logic         bodSync3;
  logic         bodLevelIn;
  logic         swRequest;
  logic [3:0]   keyWindow;
  logic [CNT_W-1:0] initCount;
  logic [CNT_W-1:0] next_initLen;
  logic         anySource;
  logic         accept;
  logic [1:0]   regIdx;
  logic         wrLow;
  logic [31:0]  next_readdata;
  logic         keyMatch;
  logic         wrCause;
  logic         wrSwReset;
  logic         wrKey;
  logic         wrBod;
  logic         releaseEdge;
  logic         next_systemReset_n;
  logic         next_debugReset_n;
  logic [3:0]   next_keyWindow;
  rsc_flags_t   next_causeFlags;
  rsc_state_e   next_state;
  logic [CNT_W-1:0] next_initCount;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: a change counts once stages two and three agree

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinSync <= 3'h7;
    end else begin
      pinSync <= {pinSync[1:0], resetPin_n};
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinLevel_n <= 1'b1;
    end else if (pinSync[1] == pinSync[2]) begin
      pinLevel_n <= pinSync[2];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bodSync1   <= 1'b0;
      bodSync2   <= 1'b0;
      bodSync3   <= 1'b0;
      bodLevelIn <= 1'b0;
    end else begin
      bodSync1 <= brownOutDetect;
      bodSync2 <= bodSync1;
      bodSync3 <= bodSync2;
      if (bodSync2 == bodSync3) begin
        bodLevelIn <= bodSync3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source gathering

  always_comb begin
    srcActive                     = '0;
    srcActive[`RSC_BIT_BROWNOUT]  = bodLevelIn;
    srcActive[`RSC_BIT_PIN]       = pinResetEnable && !pinLevel_n;
    srcActive[`RSC_BIT_WATCHDOG]  = watchdogTimeout;
    srcActive[`RSC_BIT_SOFTWARE]  = swRequest;
    srcActive[`RSC_BIT_DEBUG]     = debugResetRequest;
    anySource                     = |srcActive;
  end

  // Hold with every source quiet: the one cycle in which fuses reload
  assign releaseEdge = state == RSC_HOLD && !anySource;

  // Init length from the fuse values being reloaded
  always_comb begin
    next_initLen = CNT_W'(INIT_BASE)
                 + CNT_W'(INIT_SUT_UNIT) * CNT_W'(startupDelayFuse)
                 + (bootCrcSourceFuse ? CNT_W'(INIT_CRC) : CNT_W'(0));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer; clocked in every sleep mode, never gated

  // Any active source restarts the whole sequence, mid-init too
  always_comb begin
    next_state     = state;
    next_initCount = initCount;
    if (anySource) begin
      next_state     = RSC_HOLD;
      next_initCount = '0;
    end else begin
      unique case (state)
        RSC_HOLD: begin
          next_state     = RSC_INIT;
          next_initCount = next_initLen;
        end
        RSC_INIT: begin
          if (initCount == '0) begin
            next_state = RSC_RUN;
          end else begin
            next_initCount = initCount - CNT_W'(1);
          end
        end
        RSC_RUN: begin
          next_state = RSC_RUN;
        end
        default: begin
          next_state = RSC_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= RSC_HOLD;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      initCount <= '0;
    end else begin
      initCount <= next_initCount;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset outputs

  always_comb begin
    next_systemReset_n = !anySource && state == RSC_RUN;
    // Debug side falls only with power-on or brown-out; once up it stays up
    next_debugReset_n  = !srcActive[`RSC_BIT_BROWNOUT] && (state != RSC_HOLD || debugReset_n);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      systemReset_n <= 1'b0;
    end else begin
      systemReset_n <= next_systemReset_n;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      debugReset_n <= 1'b0;
    end else begin
      debugReset_n <= next_debugReset_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fuse shadows reload when any reset releases

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fuseReload <= 1'b0;
    end else begin
      fuseReload <= releaseEdge;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinResetEnable <= 1'b0;
      bodUnused      <= 1'b0;
      startupDelay   <= '0;
      bootCrcSource  <= 1'b0;
    end else begin
      if (releaseEdge) begin
        pinResetEnable <= pinResetFuse;
        bodUnused      <= bodUnusedFuse;
        startupDelay   <= startupDelayFuse;
        bootCrcSource  <= bootCrcSourceFuse;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bootDone <= 1'b0;
    end else if (state == RSC_RUN) begin
      bootDone <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the answer

  assign accept = (read || write) && !waitrequest;
  assign regIdx = address[3:2];
  assign wrLow  = write && accept && byteenable[0];

  // Register write strobes; only the accepting edge counts
  assign wrCause   = wrLow && regIdx == `RSC_IDX_CAUSE_FLAGS;
  assign wrSwReset = wrLow && regIdx == `RSC_IDX_SW_RESET;
  assign wrKey     = wrLow && regIdx == `RSC_IDX_PROT_KEY;
  assign wrBod     = wrLow && regIdx == `RSC_IDX_BOD_CONFIG;
  assign keyMatch  = writedata[7:0] == `RSC_IO_REGISTER_KEY;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      waitrequest <= 1'b1;
    end else if (accept) begin
      waitrequest <= 1'b1;
    end else if (read || write) begin
      waitrequest <= 1'b0;
    end
  end

  always_comb begin
    next_readdata = '0;
    unique case (regIdx)
      `RSC_IDX_CAUSE_FLAGS: next_readdata = {26'h0, causeFlags};
      `RSC_IDX_SW_RESET:    next_readdata = 32'h0;
      `RSC_IDX_PROT_KEY:    next_readdata = {31'h0, keyWindow != 4'h0};
      `RSC_IDX_BOD_CONFIG:  next_readdata = {29'h0, bodLevel};
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= '0;
    end else if (read && waitrequest) begin
      readdata <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Change protection; a pending window dies with any reset

  always_comb begin
    next_keyWindow = keyWindow;
    if (state != RSC_RUN) begin
      next_keyWindow = '0;
    end else if (wrKey && keyMatch) begin
      next_keyWindow = 4'(KEY_CYCLES);
    end else if (keyWindow != '0) begin
      next_keyWindow = keyWindow - 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      keyWindow <= '0;
    end else begin
      keyWindow <= next_keyWindow;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      swRequest <= 1'b0;
    end else begin
      // Unkeyed writes complete on the bus but change nothing
      swRequest <= wrSwReset && keyWindow != '0
                   && writedata[`RSC_BIT_SW_TRIGGER];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cause flags: survive every reset but power-on; set beats clear

  always_comb begin
    next_causeFlags = causeFlags;
    for (int i = 0; i < 6; i++) begin
      if (bootDone && srcActive[i]) begin
        next_causeFlags[i] = 1'b1;
      end else if (wrCause && writedata[i]) begin
        next_causeFlags[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      causeFlags <= `RSC_RST_CAUSE_FLAGS;
    end else begin
      causeFlags <= next_causeFlags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Brown-out configuration: cleared by power-on, and by any reset or chip erase while bodUnused is set

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bodLevel <= `RSC_RST_BOD_CONFIG;
    end else if (bodUnused && (state != RSC_RUN || chipErase)) begin
      bodLevel <= `RSC_BOD_MIN_LEVEL;
    end else if (wrBod) begin
      bodLevel <= writedata[2:0];
    end
  end

endmodule

// ### dv/rsc_checker.sv
// Port-level assertions for the reset source controller.
// Assumes the bind below; counts follow the instance parameters.
`timescale 1ns/1ns
module rsc_checker
  import rsc_pkg::*;
#(
  parameter int INIT_BASE     = 16,
  parameter int INIT_SUT_UNIT = 64,
  parameter int INIT_CRC      = 256
) (
  input wire logic              ref_clk,
  input wire logic              reset_n,
  input wire logic              write,
  input wire logic              brownOutDetect,
  input wire logic              resetPin_n,
  input wire logic              watchdogTimeout,
  input wire logic              debugResetRequest,
  input wire logic              chipErase,
  input wire logic              systemReset_n,
  input wire logic              debugReset_n,
  input wire logic              fuseReload,
  input wire logic              pinResetEnable,
  input wire logic              bodUnused,
  input wire rsc_pkg::rsc_bod_t bodLevel
);
  // Widest startup setting plus the check, with margin
  localparam int MaxInit = INIT_BASE + 3 * INIT_SUT_UNIT + INIT_CRC + 8;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_bod_quiet; !brownOutDetect [*8]; endsequence
  sequence s_pin_held; (pinResetEnable && !resetPin_n) [*7]; endsequence
  property p_init_hold; fuseReload |=> !systemReset_n [*3]; endproperty
  property p_init_bound; fuseReload |-> ##[4:MaxInit] systemReset_n; endproperty
  property p_pin_hold; s_pin_held |-> !systemReset_n; endproperty
  property p_wdt_reset; watchdogTimeout |-> ##[1:2] !systemReset_n; endproperty
  property p_dbg_reset; debugResetRequest |-> ##[1:2] !systemReset_n; endproperty
  property p_dbg_spared; s_bod_quiet ##1 $fell(systemReset_n) |-> debugReset_n [*4]; endproperty
  property p_bod_erase; bodUnused && chipErase |=> bodLevel == 3'h0; endproperty
  property p_bod_kept; !write && !chipErase && !bodUnused |=> $stable(bodLevel); endproperty
  a_init_hold: assert property (p_init_hold) else $error("early release");
  a_init_bound: assert property (p_init_bound) else $error("init too long");
  a_pin_hold: assert property (p_pin_hold) else $error("pin ignored");
  a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog ignored");
  a_dbg_reset: assert property (p_dbg_reset) else $error("debug ignored");
  a_dbg_spared: assert property (p_dbg_spared) else $error("debug side reset");
  a_bod_erase: assert property (p_bod_erase) else $error("level not forced");
  a_bod_kept: assert property (p_bod_kept) else $error("level lost");
endmodule
bind rsc_reset_source_controller rsc_checker #(
  .INIT_BASE(INIT_BASE), .INIT_SUT_UNIT(INIT_SUT_UNIT), .INIT_CRC(INIT_CRC)
) u_chk (
  .ref_clk, .reset_n, .write, .brownOutDetect, .resetPin_n, .watchdogTimeout, .debugResetRequest,
  .chipErase, .systemReset_n, .debugReset_n, .fuseReload, .pinResetEnable, .bodUnused, .bodLevel
);

// ### dv/rsc_system_model.sv
// System logic released by the controller: counts boots.
// Assumes systemReset_n is glitch free.
`timescale 1ns/1ns
module rsc_system_model (
  input  wire logic systemReset_n,
  output int        bootCount
);
  initial bootCount = 0;
  // One boot per finished reset sequence
  always @(posedge systemReset_n) bootCount <= bootCount + 1;
endmodule

// ### dv/tb_reset_source_controller.sv
// Bench: Avalon tasks, reset source drivers, cause flag checks.
// Assumes package, checker and system model compiled first.
`timescale 1ns/1ns
`include "rsc_map.svh"
module tb_reset_source_controller;
  import rsc_pkg::*;
  // Short counts keep the run brief
  localparam int SutUnit  = 2;
  localparam int CrcExtra = 4;
  logic        ref_clk = 1'b0, reset_n = 1'b0, read = 1'b0, write = 1'b0, chipErase = 1'b0;
  logic        brownOutDetect = 1'b0, resetPin_n = 1'b1, watchdogTimeout = 1'b0, debugResetRequest = 1'b0;
  logic        pinResetFuse = 1'b0, bodUnusedFuse = 1'b0, bootCrcSourceFuse = 1'b0;
  logic        waitrequest, systemReset_n, debugReset_n, fuseReload, pinResetEnable, bodUnused, bootCrcSource;
  logic [1:0]  startupDelayFuse = 2'h0, startupDelay;
  logic [3:0]  address = 4'h0, byteenable = 4'hF;
  logic [31:0] writedata = 32'h0, readdata, q;
  rsc_bod_t    bodLevel;
  int          fail_count = 0, samples_checked = 0, cycles = 0, boots = 0, bootCount, n0, n1;

  rsc_reset_source_controller #(.INIT_BASE(2), .INIT_SUT_UNIT(SutUnit), .INIT_CRC(CrcExtra)) u_dut (
    .ref_clk, .reset_n, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
    .brownOutDetect, .resetPin_n, .watchdogTimeout, .debugResetRequest, .chipErase, .pinResetFuse,
    .bodUnusedFuse, .startupDelayFuse, .bootCrcSourceFuse, .systemReset_n, .debugReset_n, .fuseReload,
    .pinResetEnable, .bodUnused, .startupDelay, .bootCrcSource, .bodLevel
  );
  rsc_system_model u_sys (.systemReset_n, .bootCount);

  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] dat);
    @(posedge ref_clk);
    address   <= adr;
    writedata <= dat;
    write     <= wr;
    read      <= !wr;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask
  // Cycles from fuse reload to release land in n1
  task automatic boot();
    n1 = 0;
    boots++;
    do @(negedge ref_clk); while (fuseReload !== 1'b1);
    while (systemReset_n !== 1'b1) begin
      @(negedge ref_clk);
      n1++;
    end
  endtask
  task automatic cause(input logic [31:0] exp);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, exp);
    bus(1'b1, 4'h0, 32'h3F);
  endtask
  // Brown-out, debug, watchdog held until the reset shows
  task automatic src(input logic [2:0] s, input logic [31:0] exp);
    @(posedge ref_clk) {brownOutDetect, debugResetRequest, watchdogTimeout} <= s;
    do @(negedge ref_clk); while (systemReset_n !== 1'b0);
    @(posedge ref_clk) {brownOutDetect, debugResetRequest, watchdogTimeout} <= 3'h0;
    boot();
    cause(exp);
  endtask
  task automatic pin_low(input logic exp);
    @(posedge ref_clk) resetPin_n <= 1'b0;
    repeat (10) @(negedge ref_clk);
    chk(systemReset_n, exp);
    @(posedge ref_clk) resetPin_n <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    boot();
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h01);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h0);
    pin_low(1'b1);
    src(3'h1, 32'h09);
    n0 = n1;
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0);
    startupDelayFuse <= 2'h2;
    src(3'h1, 32'h08);
    chk(32'(n1 - n0), 32'(2 * SutUnit));
    chk(startupDelay, 2'h2);
    startupDelayFuse <= 2'h0;
    bootCrcSourceFuse <= 1'b1;
    src(3'h1, 32'h08);
    chk(32'(n1 - n0), 32'(CrcExtra));
    chk(bootCrcSource, 1'b1);
    bootCrcSourceFuse <= 1'b0;
    bus(1'b1, 4'h4, 32'h1);
    repeat (12) @(negedge ref_clk);
    chk(systemReset_n, 1'b1);
    bus(1'b1, 4'h8, 32'(`RSC_IO_REGISTER_KEY));
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h1);
    bus(1'b1, 4'h4, 32'h1);
    boot();
    cause(32'h10);
    pinResetFuse <= 1'b1;
    bus(1'b1, 4'hC, 32'h5);
    src(3'h3, 32'h28);
    chk(pinResetEnable, 1'b1);
    chk(debugReset_n, 1'b1);
    chk(bodLevel, 3'h5);
    pin_low(1'b0);
    boot();
    cause(32'h04);
    src(3'h4, 32'h02);
    chk(bodLevel, 3'h5);
    @(posedge ref_clk) reset_n <= 1'b0;
    @(negedge ref_clk);
    chk({systemReset_n, debugReset_n, bodLevel}, 5'h0);
    @(posedge ref_clk) reset_n <= 1'b1;
    do @(negedge ref_clk); while (fuseReload !== 1'b1);
    @(posedge ref_clk) watchdogTimeout <= 1'b1;
    @(posedge ref_clk) watchdogTimeout <= 1'b0;
    boot();
    cause(32'h01);
    bodUnusedFuse <= 1'b1;
    src(3'h1, 32'h08);
    bus(1'b1, 4'hC, 32'h5);
    @(posedge ref_clk) chipErase <= 1'b1;
    @(negedge ref_clk);
    @(negedge ref_clk);
    chk(bodLevel, 3'h0);
    @(posedge ref_clk) chipErase <= 1'b0;
    chk(32'(bootCount), 32'(boots));
    end_of_test();
  end
endmodule
